// ==== core/fpdc_top.sv ====
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fpdc_map.svh"

module fpdc_top #(
    parameter int unsigned RAMP_BASE_CYC = `FPDC_RAMP_BASE_CYC,
    parameter int unsigned SPIN_CYC      = `FPDC_SPIN_CYC,
    parameter int unsigned SLOT_20HZ     = `FPDC_SLOT_CYC(20),
    parameter int unsigned SLOT_33HZ     = `FPDC_SLOT_CYC(33),
    parameter int unsigned SLOT_50HZ     = `FPDC_SLOT_CYC(50),
    parameter int unsigned SLOT_100HZ    = SLOT_50HZ / 2
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [6:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    output logic      [31:0] avsReaddata,
    output logic             avsWaitrequest,
    input  wire logic [7:0]  remoteTemp,
    input  wire logic [7:0]  localTemp,
    output logic             fanDriveOut
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] configReg;
    logic [7:0] startDuty;
    logic [7:0] maxDuty;
    logic [7:0] manualTarget;
    logic [7:0] thrRemote;
    logic [7:0] thrLocal;
    logic [7:0] fanCfg;
    logic [7:0] dutyRampRate;
    logic [7:0] dutyStepSize;
    logic [7:0] outputFrequencySelect;
    logic [7:0] instDuty;

    wire        busReq    = avsRead | avsWrite;
    wire        accept    = busReq & ~avsWaitrequest;
    wire        aligned   = (avsAddress[1:0] == 2'b00);
    wire [4:0]  regIdx    = avsAddress[6:2];
    wire        wrAccept  = accept & avsWrite & aligned;
    wire [7:0]  wrByte    = avsWritedata[7:0];

    fpdc_pkg::fpdc_cfg_s cfg;
    assign cfg = '{invert:  configReg[`FPDC_BIT_INVERT],
                   minDuty: configReg[`FPDC_BIT_MIN_DUTY],
                   spinOff: configReg[`FPDC_BIT_SPIN_OFF]};

    logic [7:0] targetEff;
    logic [7:0] readMux;

    always_comb begin
        readMux = 8'h00;
        if (aligned) begin
            case (regIdx)
                `FPDC_IDX_CONFIG:     readMux = configReg;
                `FPDC_IDX_START_DUTY: readMux = startDuty;
                `FPDC_IDX_MAX_DUTY:   readMux = maxDuty;
                `FPDC_IDX_TARGET:     readMux = targetEff;
                `FPDC_IDX_INST:       readMux = instDuty;
                `FPDC_IDX_THR_REM:    readMux = thrRemote;
                `FPDC_IDX_THR_LOC:    readMux = thrLocal;
                `FPDC_IDX_FAN_CFG:    readMux = fanCfg;
                `FPDC_IDX_RAMP:       readMux = dutyRampRate;
                `FPDC_IDX_STEP:       readMux = dutyStepSize;
                `FPDC_IDX_FREQ:       readMux = outputFrequencySelect;
                default:              readMux = 8'h00;
            endcase
        end
    end

    // One wait cycle per access; readdata is settled when waitrequest drops
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            avsWaitrequest <= 1'b1;
            avsReaddata    <= 32'h0000_0000;
        end else begin
            avsWaitrequest <= ~(busReq & avsWaitrequest);
            if (busReq & avsWaitrequest) begin
                avsReaddata <= {24'h000000, readMux};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            configReg             <= `FPDC_RST_CONFIG;
            startDuty             <= `FPDC_RST_START_DUTY;
            maxDuty               <= `FPDC_RST_MAX_DUTY;
            manualTarget          <= `FPDC_RST_TARGET;
            thrRemote             <= `FPDC_RST_THR;
            thrLocal              <= `FPDC_RST_THR;
            fanCfg                <= `FPDC_RST_FAN_CFG;
            dutyRampRate          <= `FPDC_RST_RAMP;
            dutyStepSize          <= `FPDC_RST_STEP;
            outputFrequencySelect <= `FPDC_RST_FREQ;
        end else if (wrAccept) begin
            case (regIdx)
                `FPDC_IDX_CONFIG:     configReg             <= wrByte;
                `FPDC_IDX_START_DUTY: startDuty             <= wrByte;
                `FPDC_IDX_MAX_DUTY:   maxDuty               <= wrByte;
                `FPDC_IDX_TARGET:     manualTarget          <= wrByte;
                `FPDC_IDX_THR_REM:    thrRemote             <= wrByte;
                `FPDC_IDX_THR_LOC:    thrLocal              <= wrByte;
                `FPDC_IDX_FAN_CFG:    fanCfg                <= wrByte;
                `FPDC_IDX_RAMP:       dutyRampRate          <= wrByte;
                `FPDC_IDX_STEP:       dutyStepSize          <= wrByte;
                `FPDC_IDX_FREQ:       outputFrequencySelect <= wrByte;
                default:              ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Duty law
    // ------------------------------------------------------------
    function automatic logic [7:0] clip240(input logic [13:0] v);
        clip240 = (v > 14'(`FPDC_FULL_DUTY)) ? `FPDC_FULL_DUTY : v[7:0];
    endfunction : clip240

    function automatic logic [7:0] autoDuty(input logic [7:0] temp,
                                            input fpdc_pkg::fpdc_law_s law);
        logic [7:0]  over;
        logic [7:0]  steps;
        logic [13:0] raw;
        logic [7:0]  limited;
        logic [7:0]  maxLim;
        over    = temp - law.threshold;
        steps   = law.tempStep2 ? {1'b0, over[7:1]} : over;
        raw     = 14'(law.startDuty) + 14'(steps) * 14'({law.stepCode, 1'b0});
        maxLim  = clip240(14'(law.maxDuty));
        if (temp < law.threshold) begin
            raw = law.minDuty ? 14'(law.startDuty) : 14'h0000;
        end
        limited = clip240(raw);
        if (limited > maxLim) begin
            limited = maxLim;
        end
        autoDuty = {limited[7:1], 1'b0};
    endfunction : autoDuty

    fpdc_pkg::fpdc_law_s lawRemote;
    fpdc_pkg::fpdc_law_s lawLocal;
    assign lawRemote = '{startDuty: startDuty, threshold: thrRemote,
                         stepCode: dutyStepSize[7:4], tempStep2: fanCfg[`FPDC_BIT_TSTEP],
                         minDuty: cfg.minDuty, maxDuty: maxDuty};
    assign lawLocal  = '{startDuty: startDuty, threshold: thrLocal,
                         stepCode: dutyStepSize[7:4], tempStep2: fanCfg[`FPDC_BIT_TSTEP],
                         minDuty: cfg.minDuty, maxDuty: maxDuty};

    wire [7:0]  dutyRemote = autoDuty(remoteTemp, lawRemote);
    wire [7:0]  dutyLocal  = autoDuty(localTemp, lawLocal);
    wire        useRemote  = fanCfg[`FPDC_BIT_REMOTE];
    wire        useLocal   = fanCfg[`FPDC_BIT_LOCAL];
    wire        manualMode = ~useRemote & ~useLocal;
    wire [7:0]  manualEff  = clip240(14'(manualTarget));
    wire [7:0]  bothEff    = (dutyRemote > dutyLocal) ? dutyRemote : dutyLocal;
    wire [7:0]  autoEff    = (useRemote & useLocal) ? bothEff :
                             (useRemote ? dutyRemote : dutyLocal);

    assign targetEff = manualMode ? manualEff : autoEff;

    // ------------------------------------------------------------
    // Ramp interval timing
    // ------------------------------------------------------------
    logic [31:0] baseCnt;
    logic [6:0]  rampCnt;

    wire [2:0]  rampCode   = dutyRampRate[7:5];
    wire        baseTick   = (baseCnt >= RAMP_BASE_CYC - 1);
    wire [6:0]  rampLen    = 7'h01 << (rampCode - 3'h1);
    wire        rampDue    = baseTick & (rampCnt >= rampLen - 7'h01);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            baseCnt <= 32'h0000_0000;
        end else begin
            baseCnt <= baseTick ? 32'h0000_0000 : baseCnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rampCnt <= 7'h00;
        end else if (baseTick) begin
            rampCnt <= rampDue ? 7'h00 : rampCnt + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Instantaneous duty and spin-up kick
    // ------------------------------------------------------------
    fpdc_pkg::fpdc_state_e state;
    logic [31:0]           spinCnt;

    wire        startReq   = (instDuty == 8'h00) & (targetEff != 8'h00);
    wire        spinDone   = (spinCnt >= SPIN_CYC - 1);
    wire [7:0]  stepUp     = ((targetEff - instDuty) < 8'h02) ? targetEff : instDuty + 8'h02;
    wire [7:0]  stepDown   = ((instDuty - targetEff) < 8'h02) ? targetEff : instDuty - 8'h02;
    wire [7:0]  rampNext   = (targetEff > instDuty) ? stepUp : stepDown;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            spinCnt <= 32'h0000_0000;
        end else begin
            spinCnt <= (state == fpdc_pkg::FPDC_KICK) ? spinCnt + 32'h0000_0001
                                                      : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state    <= fpdc_pkg::FPDC_RUN;
            instDuty <= 8'h00;
        end else begin
            case (state)
                fpdc_pkg::FPDC_RUN: begin
                    if (startReq & cfg.spinOff) begin
                        instDuty <= targetEff;
                    end else if (startReq) begin
                        state <= fpdc_pkg::FPDC_KICK;
                    end else if (rampCode == 3'b000) begin
                        instDuty <= targetEff;
                    end else if (rampDue) begin
                        instDuty <= rampNext;
                    end
                end
                fpdc_pkg::FPDC_KICK: begin
                    if (targetEff == 8'h00) begin
                        state <= fpdc_pkg::FPDC_RUN;
                    end else if (spinDone) begin
                        instDuty <= targetEff;
                        state    <= fpdc_pkg::FPDC_RUN;
                    end
                end
                default: begin
                    state <= fpdc_pkg::FPDC_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output period and drive
    // ------------------------------------------------------------
    wire        fastMode  = outputFrequencySelect[`FPDC_BIT_FAST];
    wire [1:0]  freqSel   = outputFrequencySelect[7:6];
    wire [15:0] slowSlot  = (freqSel == 2'b00) ? 16'(SLOT_20HZ) :
                            (freqSel == 2'b01) ? 16'(SLOT_33HZ) :
                            (freqSel == 2'b10) ? 16'(SLOT_50HZ) : 16'(SLOT_100HZ);
    wire [15:0] slotCyc   = fastMode ? 16'(`FPDC_SLOT_CYC(35000)) : slowSlot;
    wire [7:0]  pwmDuty   = fastMode ? {instDuty[7:2], 2'b00} : instDuty;
    logic       slotActive;

    fpdc_slot_pwm u_slot_pwm (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .slotCycles (slotCyc),
        .duty       (pwmDuty),
        .slotActive (slotActive)
    );

    wire        activeLvl = slotActive ? cfg.invert : ~cfg.invert;

    // Kick is a true high, whatever the polarity
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            fanDriveOut <= 1'b1;
        end else begin
            fanDriveOut <= (state == fpdc_pkg::FPDC_KICK) ? 1'b1 : activeLvl;
        end
    end

endmodule : fpdc_top

`default_nettype wire

// ==== core/fpdc_map.svh ====
// Functional notes
// - Ramp code bits 7..5; 000 immediate, 001..111 give 0.0625 s doubling to 4 s.
// - Step code bits 7..4 value n changes duty by 2n/240 per temperature step.
// - Frequency bit 7..5; bit 5 set gives 35 kHz, else 20/33/50/100 Hz.
// - Frequency-select register resets to 40h, selecting 33 Hz.
// - At 35 kHz the duty resolution coarsens to 4/240.
// - Polarity bit 4: 0 drives output low at full duty, 1 drives it high.
// - Start from standstill holds the output high for 2 s.
// - After the kick the duty moves to the computed value.
// - Spin-up inhibit bit 2 jumps straight to nominal duty, no kick, no ramp.
// - Source bits D5 D4 both zero select manual duty from written target.
// - Manual target above 240 is clipped to 240.
// - Manual mode ignores the maximum-duty limit.
// - Auto below start temperature gives zero or fan-start duty, chosen by D3.
// - Auto above start adds one increment per temperature step over threshold.
// - D5 remote, D4 local; both set takes the larger computed duty.
// - Instantaneous duty moves 2/240 toward target once per ramp interval.
// - Ramp applies in manual mode too unless the ramp code is zero.
`ifndef FPDC_MAP_SVH
`define FPDC_MAP_SVH

`define FPDC_CLK_HZ         100000000
`define FPDC_SLOTS          240
`define FPDC_FULL_DUTY      8'hF0
`define FPDC_SLOT_CYC(f)    (`FPDC_CLK_HZ / ((f) * `FPDC_SLOTS))
`define FPDC_RAMP_BASE_US   62500
`define FPDC_RAMP_BASE_CYC  (`FPDC_CLK_HZ / 1000000 * `FPDC_RAMP_BASE_US)
`define FPDC_SPIN_MS        2000
`define FPDC_SPIN_CYC       (`FPDC_CLK_HZ / 1000 * `FPDC_SPIN_MS)

// Register indices; byte address is four times the index
`define FPDC_IDX_CONFIG     5'h02
`define FPDC_IDX_START_DUTY 5'h07
`define FPDC_IDX_MAX_DUTY   5'h08
`define FPDC_IDX_TARGET     5'h09
`define FPDC_IDX_INST       5'h0A
`define FPDC_IDX_THR_REM    5'h0B
`define FPDC_IDX_THR_LOC    5'h0C
`define FPDC_IDX_FAN_CFG    5'h0D
`define FPDC_IDX_RAMP       5'h0E
`define FPDC_IDX_STEP       5'h0F
`define FPDC_IDX_FREQ       5'h10

`define FPDC_RST_CONFIG     8'h00
`define FPDC_RST_START_DUTY 8'h60
`define FPDC_RST_MAX_DUTY   8'hF0
`define FPDC_RST_TARGET     8'h00
`define FPDC_RST_THR        8'h00
`define FPDC_RST_FAN_CFG    8'h00
`define FPDC_RST_RAMP       8'hA0
`define FPDC_RST_STEP       8'h50
`define FPDC_RST_FREQ       8'h40

`define FPDC_BIT_INVERT     4
`define FPDC_BIT_MIN_DUTY   3
`define FPDC_BIT_SPIN_OFF   2
`define FPDC_BIT_HYST       7
`define FPDC_BIT_TSTEP      6
`define FPDC_BIT_REMOTE     5
`define FPDC_BIT_LOCAL      4
`define FPDC_BIT_FAST       5

`endif

// ==== core/fpdc_pkg.sv ====
package fpdc_pkg;

    typedef enum logic [1:0] {
        FPDC_RUN  = 2'b01,
        FPDC_KICK = 2'b10
    } fpdc_state_e;

    typedef struct packed {
        logic invert;
        logic minDuty;
        logic spinOff;
    } fpdc_cfg_s;

    typedef struct packed {
        logic [7:0] startDuty;
        logic [7:0] threshold;
        logic [3:0] stepCode;
        logic       tempStep2;
        logic       minDuty;
        logic [7:0] maxDuty;
    } fpdc_law_s;

endpackage : fpdc_pkg

// ==== core/fpdc_slot_pwm.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fpdc_map.svh"

module fpdc_slot_pwm (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] slotCycles,
    input  wire logic [7:0]  duty,
    output logic             slotActive
);

    logic [15:0] divCnt;
    logic [7:0]  slot;
    logic [7:0]  dutyLatched;

    wire         slotTick = (divCnt >= slotCycles - 16'h0001);
    wire         lastSlot = (slot == 8'(`FPDC_SLOTS - 1));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            divCnt <= 16'h0000;
        end else begin
            divCnt <= slotTick ? 16'h0000 : divCnt + 16'h0001;
        end
    end

    // Duty taken only at period start so a change never splits a period
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slot        <= 8'h00;
            dutyLatched <= 8'h00;
        end else if (slotTick) begin
            slot <= lastSlot ? 8'h00 : slot + 8'h01;
            if (lastSlot) begin
                dutyLatched <= duty;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slotActive <= 1'b0;
        end else begin
            slotActive <= (slot < dutyLatched);
        end
    end

endmodule : fpdc_slot_pwm

`default_nettype wire

// ==== testbench/fpdc_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the fan duty block
// ----------------------------------------
module fpdc_top_sva (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [6:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    input  wire logic [31:0] avsReaddata,
    input  wire logic        avsWaitrequest,
    input  wire logic [7:0]  remoteTemp,
    input  wire logic [7:0]  localTemp,
    input  wire logic        fanDriveOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic       req    = avsRead | avsWrite;
    wire logic [4:0] idx    = avsAddress[6:2];
    wire logic       mapped = (avsAddress[1:0] == 2'b00)
                              && (idx == 5'h02 || (idx >= 5'h07 && idx <= 5'h10));
    wire logic       dutyRd = avsAddress == 7'h24 || avsAddress == 7'h28;

    a_wait_answer: assert property (req && avsWaitrequest |=> !avsWaitrequest)
        else $error("request not answered after one wait state");
    a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest)
        else $error("waitrequest low for more than one cycle");
    a_ack_cause: assert property (!avsWaitrequest |-> $past(req))
        else $error("waitrequest low without a request");
    a_read_upper: assert property (avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_read_hold: assert property (!req |=> $stable(avsReaddata))
        else $error("read data changed without an access");
    a_reset_state: assert property ($rose(resetn) |-> avsWaitrequest && fanDriveOut)
        else $error("outputs wrong at reset release");
    a_duty_clip: assert property (avsRead && !avsWaitrequest && dutyRd |-> avsReaddata <= 32'hF0)
        else $error("duty register read above full scale");
    a_unmapped_zero: assert property (avsRead && avsWaitrequest && !mapped |=> avsReaddata == 32'h0)
        else $error("unmapped read returned data");
    a_slot_width: assert property ($changed(fanDriveOut) ##1 $changed(fanDriveOut)
                                   |=> $stable(fanDriveOut))
        else $error("output changed in three cycles in a row");

    cover property (avsWrite && !avsWaitrequest);
    cover property (avsRead && !avsWaitrequest && !mapped);
    cover property ($rose(fanDriveOut));
endmodule : fpdc_top_sva
`default_nettype wire

// ==== testbench/fpdc_fan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Fan drive stage: counts level per cycle
// ----------------------------------------
module fpdc_fan_model (
    input  wire logic ref_clk,
    input  wire logic fanDriveOut,
    input  wire logic countEn,
    output var  int   highCnt,
    output var  int   lowCnt
);
    // Window must span whole periods, else phase skews the count
    always @(posedge ref_clk) begin
        if (!countEn) begin
            highCnt <= 0;
            lowCnt  <= 0;
        end else if (fanDriveOut) begin
            highCnt <= highCnt + 1;
        end else begin
            lowCnt <= lowCnt + 1;
        end
    end
endmodule : fpdc_fan_model
`default_nettype wire

// ==== testbench/test_fan_pwm_duty_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_fan_pwm_duty_control;
    logic        ref_clk      = 1'b0;
    logic        resetn       = 1'b0;
    logic [6:0]  avsAddress   = 7'h00;
    logic        avsRead      = 1'b0;
    logic        avsWrite     = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic [7:0]  remoteTemp   = 8'h00;
    logic [7:0]  localTemp    = 8'h00;
    logic        fanDriveOut;
    logic        countEn      = 1'b0;
    int          highCnt;
    int          lowCnt;
    int          errTotal     = 0;
    int          nChecks      = 0;
    logic [31:0] seed         = 32'h0B6C7190;
    logic [31:0] rd;
    logic [7:0]  v;
    int          t1, t2, iv, cur, d, p, lt, rt, n, s2, mn, cfg, mx;
    logic [4:0]  rIdx [11]  = '{5'h02, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
                                5'h0E, 5'h0F, 5'h10};
    logic [7:0]  rRst [11]  = '{8'h00, 8'h60, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'hA0, 8'h50, 8'h40};
    logic [4:0]  rwIdx [8]  = '{5'h02, 5'h07, 5'h08, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h10};
    logic [7:0]  fCode [5]  = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hE0};
    int          slotTab [5] = '{2, 3, 8, 4, 11};
    int          srcTab [6]  = '{8'h10, 8'h20, 8'h30, 8'h50, 8'h60, 8'h70};

    always #5 ref_clk = ~ref_clk;

    fpdc_top #(.RAMP_BASE_CYC(20), .SPIN_CYC(50), .SLOT_20HZ(2), .SLOT_33HZ(3),
               .SLOT_50HZ(8)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .remoteTemp(remoteTemp), .localTemp(localTemp),
        .fanDriveOut(fanDriveOut));
    fpdc_fan_model fan (.ref_clk(ref_clk), .fanDriveOut(fanDriveOut), .countEn(countEn),
                        .highCnt(highCnt), .lowCnt(lowCnt));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr

    function automatic int law(int t, int thr, int n, int s2, int mn, int mx);
        int r;
        if (t < thr) r = mn ? 96 : 0;
        else r = 96 + 2 * n * ((t - thr) / (s2 ? 2 : 1));
        if (r > 240) r = 240;
        if (r > mx) r = mx;
        return r & ~1;
    endfunction : law

    task automatic conclude;
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int k;
        k = 0;
        @(posedge ref_clk);
        avsAddress   <= a;
        avsWritedata <= wd;
        avsWrite     <= w;
        avsRead      <= !w;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avsWaitrequest !== 1'b0 && k < 20);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        if (k >= 20) begin
            errTotal++;
            conclude();
        end
    endtask : bus

    task automatic wr(input logic [4:0] i, input logic [7:0] val);
        bus(1'b1, {i, 2'b00}, {24'h0, val}, rd);
    endtask : wr

    task automatic rdc(input logic [4:0] i, input logic [31:0] e);
        bus(1'b0, {i, 2'b00}, 32'h0, rd);
        chk(rd, e);
    endtask : rdc

    task automatic waitInst(input logic [7:0] val, output int t);
        int k;
        k = 0;
        do begin
            bus(1'b0, 7'h28, 32'h0, rd);
            k++;
        end while (rd[7:0] !== val && k < 400);
        t = int'($time / 10);
        if (k >= 400) begin
            errTotal++;
            conclude();
        end
    endtask : waitInst

    initial begin
        repeat (100000) @(posedge ref_clk);
        errTotal++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 11; i++) rdc(rIdx[i], {24'h0, rRst[i]});
        wr(5'h11, 8'h5A);
        bus(1'b0, 7'h44, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, 7'h41, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset and map done");
        wr(5'h09, 8'hFF);
        rdc(5'h09, 32'hF0);
        for (int k = 0; k < 32; k++) begin
            seed = lfsr(seed);
            v = (k % 8 == 0) ? (seed[7:0] & 8'h1C) : seed[7:0];
            wr(rwIdx[k % 8], v);
            rdc(rwIdx[k % 8], {24'h0, v});
            wr(5'h09, seed[15:8]);
            rdc(5'h09, seed[15:8] > 8'hF0 ? 32'hF0 : {24'h0, seed[15:8]});
        end
        $display("test readback done");
        wr(5'h10, 8'h40);
        wr(5'h02, 8'h04);
        wr(5'h0E, 8'h00);
        wr(5'h08, 8'h10);
        wr(5'h09, 8'h00);
        wr(5'h0E, 8'hE0);
        wr(5'h09, 8'h64);
        rdc(5'h0A, 32'h64);
        wr(5'h0A, 8'h00);
        rdc(5'h0A, 32'h64);
        cur = 8'h64;
        for (int c = 1; c < 5; c++) begin
            cur = cur + 4;
            iv = 20 << (c - 1);
            wr(5'h0E, 8'(c << 5));
            wr(5'h09, 8'(cur));
            waitInst(8'(cur - 2), t1);
            waitInst(8'(cur), t2);
            chk(32'(t2 - t1 >= iv - 4 && t2 - t1 <= iv + 4), 32'h1);
        end
        $display("test ramp done");
        wr(5'h02, 8'h10);
        wr(5'h0E, 8'h00);
        wr(5'h09, 8'h00);
        repeat (800) @(posedge ref_clk);
        rdc(5'h0A, 32'h0);
        chk({31'h0, fanDriveOut}, 32'h0);
        wr(5'h09, 8'h78);
        repeat (3) @(posedge ref_clk);
        for (int k = 0; k < 44; k++) begin
            @(posedge ref_clk);
            chk({31'h0, fanDriveOut}, 32'h1);
        end
        repeat (20) @(posedge ref_clk);
        rdc(5'h0A, 32'h78);
        $display("test kick done");
        wr(5'h02, 8'h14);
        wr(5'h09, 8'h76);
        for (int f = 0; f < 6; f++) begin
            if (f == 5) wr(5'h02, 8'h04);
            wr(5'h10, fCode[f % 5]);
            p = 240 * slotTab[f % 5];
            d = (f == 4) ? 8'h74 : 8'h76;
            repeat (2640 + p) @(posedge ref_clk);
            countEn <= 1'b1;
            repeat (p) @(posedge ref_clk);
            countEn <= 1'b0;
            @(posedge ref_clk);
            chk((f == 5) ? lowCnt : highCnt, d * slotTab[f % 5]);
        end
        $display("test output shape done");
        wr(5'h0B, 8'h32);
        wr(5'h0C, 8'h28);
        wr(5'h07, 8'h60);
        for (int k = 0; k < 32; k++) begin
            seed = lfsr(seed);
            lt = 30 + int'(seed[7:0]) % 40;
            rt = 30 + int'(seed[15:8]) % 40;
            cfg = srcTab[int'(seed[23:16]) % 6];
            mn = seed[24];
            mx = 8'h80 + seed[31:25];
            n = k % 16;
            s2 = cfg[6];
            localTemp  <= 8'(lt);
            remoteTemp <= 8'(rt);
            wr(5'h02, mn ? 8'h0C : 8'h04);
            wr(5'h08, 8'(mx));
            wr(5'h0F, 8'(n << 4));
            wr(5'h0D, 8'(cfg));
            d = cfg[4] ? law(lt, 40, n, s2, mn, mx) : 0;
            t1 = cfg[5] ? law(rt, 50, n, s2, mn, mx) : 0;
            if (t1 > d) d = t1;
            repeat (4) @(posedge ref_clk);
            rdc(5'h09, d);
            rdc(5'h0A, d);
        end
        $display("test automatic law done");
        conclude();
    end
endmodule : test_fan_pwm_duty_control

bind fpdc_top fpdc_top_sva u_sva (
    .ref_clk(ref_clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .remoteTemp(remoteTemp), .localTemp(localTemp),
    .fanDriveOut(fanDriveOut));
`default_nettype wire
